// >>> logic/pms_pkg.sv
// Shared constants and state encodings of the serial management link.
// Assumes both ends run on one 20 MHz system clock; the station makes the management clock.
package pms_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam logic [4:0] PMS_PHY_ADDR = 5'h10;
  localparam logic [1:0] PMS_START = 2'h1;
  localparam logic [1:0] PMS_OP_READ = 2'h2;
  localparam logic [1:0] PMS_OP_WRITE = 2'h1;
  localparam logic [1:0] PMS_TA_WRITE = 2'h2;
  localparam int PMS_ADDR_W = 5;
  localparam int PMS_DATA_W = 16;
  localparam int PMS_PRE_BITS = 32;
  localparam int PMS_FRAME_BITS = 64;
  localparam int PMS_SLOT_W = 7;
  localparam logic [6:0] PMS_SLOT_NOPRE = 7'h20;
  localparam logic [6:0] PMS_SLOT_TA = 7'h2e;
  localparam logic [6:0] PMS_SLOT_DATA = 7'h30;
  localparam logic [6:0] PMS_SLOT_END = 7'h40;
  localparam logic [31:0] PMS_PREAMBLE = 32'hffffffff;

  // ----------------------------------------------------------------
  // Bit counts inside the slave's frame states
  // ----------------------------------------------------------------
  localparam logic [3:0] PMS_CNT_OP_LAST = 4'h1;
  localparam logic [3:0] PMS_CNT_ADDR_LAST = 4'h4;
  localparam logic [3:0] PMS_CNT_TA_LAST = 4'h1;
  localparam logic [3:0] PMS_CNT_DATA_LAST = 4'hf;

  // ----------------------------------------------------------------
  // Register file of the slave
  // ----------------------------------------------------------------
  localparam int PMS_NUM_REGS = 32;
  localparam logic [4:0] PMS_REG_BASIC_STATUS = 5'h01;
  localparam int PMS_BSR_NOPRE_BIT = 6;
  localparam logic [15:0] PMS_BSR_RESET = 16'h0040;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int PMS_SYS_CLK_NS = 50;
  localparam int PMS_MDC_MAX_KHZ = 2500;
  localparam int PMS_MDC_MIN_PERIOD_NS = 1000000 / PMS_MDC_MAX_KHZ;
  localparam int PMS_MDC_DIV = (PMS_MDC_MIN_PERIOD_NS + PMS_SYS_CLK_NS - 1) / PMS_SYS_CLK_NS;
  localparam logic [2:0] PMS_MDC_HALF = 3'(PMS_MDC_DIV / 2);
  localparam logic [2:0] PMS_MDC_LAST = 3'(PMS_MDC_DIV - 1);

  // ----------------------------------------------------------------
  // State encodings
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    PMS_S_IDLE = 7'b0000001,
    PMS_S_START = 7'b0000010,
    PMS_S_OP = 7'b0000100,
    PMS_S_PHYAD = 7'b0001000,
    PMS_S_REGAD = 7'b0010000,
    PMS_S_TA = 7'b0100000,
    PMS_S_DATA = 7'b1000000
  } pms_slave_e;

  typedef enum logic [1:0] {
    PMS_M_IDLE = 2'b01,
    PMS_M_RUN = 2'b10
  } pms_master_e;

endpackage

// >>> logic/pms_if.sv
// Two-wire management link between station and slave.
// Resolves the shared data line from both enables; released line reads 1 by the pull-up.
`timescale 1ns/100ps
`default_nettype none
interface pms_if;
  logic mdc;
  logic sta_mdio_o;
  logic sta_mdio_oe;
  logic phy_mdio_o;
  logic phy_mdio_oe;
  logic mdio;

  // A released line reads high, as the slave's pull-up makes it.
  always_comb begin
    if (phy_mdio_oe) begin
      mdio = phy_mdio_o;
    end else if (sta_mdio_oe) begin
      mdio = sta_mdio_o;
    end else begin
      mdio = 1'b1;
    end
  end

  modport phy (input mdc, input mdio, output phy_mdio_o, output phy_mdio_oe);
  modport station (output mdc, output sta_mdio_o, output sta_mdio_oe, input mdio);
endinterface
`default_nettype wire

// >>> logic/pms_phy_slave.sv
// Management slave of the PHY: decodes frames on the link and serves its 32 registers.
// Assumes the station keeps the clock within its limit and completes every frame.
//
// Contract
// - Station clock no faster than 2.5 MHz.
// - PHY answers only fixed address 10h.
// - Fields: preamble, start, op, addresses, turnaround, data, idle.
// - Station sends each frame without interruption.
// - Preamble optional; status bit 6 reports it.
// - Frame start only on pattern 01.
// - Opcode 10 reads, 01 writes.
// - PHY address five bits, MSB first.
// - Register address five bits, MSB first.
// - Write turnaround driven as 1 then 0.
// - Sixteen data bits, bit 15 first.
// - Idle line: all drivers released.
// - Pull-up holds released line at 1.
// - Station knows each PHY address beforehand.
`timescale 1ns/100ps
`default_nettype none
module pms_phy_slave
  import pms_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Management link
  pms_if.phy link,
  // Notice of a register written over the link
  output logic wr_stb_r,
  output logic [4:0] wr_addr_r,
  output logic [15:0] wr_data_r
);

  // ----------------------------------------------------------------
  // Synchronisers and edge detect
  // ----------------------------------------------------------------
  logic [1:0] sync1_r;
  logic [1:0] sync2_r;
  logic mdc_prev_r;
  logic rise;
  logic bit_in;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      // Idle levels, clock low and line high, so no false rise follows reset.
      sync1_r <= 2'h1;
      sync2_r <= 2'h1;
      mdc_prev_r <= 1'b0;
    end else begin
      sync1_r <= {link.mdc, link.mdio};
      sync2_r <= sync1_r;
      mdc_prev_r <= sync2_r[1];
    end
  end

  assign rise = sync2_r[1] & ~mdc_prev_r;
  assign bit_in = sync2_r[0];

  // ----------------------------------------------------------------
  // Frame decoder
  // ----------------------------------------------------------------
  pms_slave_e state_r;
  logic [3:0] cnt_r;
  logic [1:0] op_r;
  logic [4:0] phy_r;
  logic [4:0] reg_r;
  logic [15:0] shift_r;
  logic hit_r;
  logic is_read_r;
  logic mdio_o_r;
  logic mdio_oe_r;
  logic [15:0] regs_r [PMS_NUM_REGS];
  logic [15:0] rd_word;
  logic addr_hit;
  logic op_read;
  logic op_write;

  // The no-preamble capability is wired high, whatever was written.
  always_comb begin
    rd_word = regs_r[reg_r];
    if (reg_r == PMS_REG_BASIC_STATUS) begin
      rd_word[PMS_BSR_NOPRE_BIT] = 1'b1;
    end
  end

  assign addr_hit = (phy_r == PMS_PHY_ADDR);
  assign op_read = (op_r == PMS_OP_READ);
  assign op_write = (op_r == PMS_OP_WRITE);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= PMS_S_IDLE;
      cnt_r <= 4'h0;
      op_r <= 2'h0;
      phy_r <= 5'h0;
      reg_r <= 5'h0;
      hit_r <= 1'b0;
      is_read_r <= 1'b0;
    end else if (rise) begin
      case (state_r)
        PMS_S_IDLE: begin
          // Ones of a preamble or of idle are simply skipped, so no preamble is needed.
          if (!bit_in) begin
            state_r <= PMS_S_START;
          end
        end
        PMS_S_START: begin
          cnt_r <= 4'h0;
          state_r <= bit_in ? PMS_S_OP : PMS_S_IDLE;
        end
        PMS_S_OP: begin
          op_r <= {op_r[0], bit_in};
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == PMS_CNT_OP_LAST) begin
            cnt_r <= 4'h0;
            state_r <= PMS_S_PHYAD;
          end
        end
        PMS_S_PHYAD: begin
          phy_r <= {phy_r[3:0], bit_in};
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == PMS_CNT_ADDR_LAST) begin
            cnt_r <= 4'h0;
            state_r <= PMS_S_REGAD;
          end
        end
        PMS_S_REGAD: begin
          reg_r <= {reg_r[3:0], bit_in};
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == PMS_CNT_ADDR_LAST) begin
            cnt_r <= 4'h0;
            hit_r <= addr_hit;
            is_read_r <= op_read;
            // A frame with an undefined opcode is dropped and the hunt for a start resumes.
            state_r <= (op_read | op_write) ? PMS_S_TA : PMS_S_IDLE;
          end
        end
        PMS_S_TA: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == PMS_CNT_TA_LAST) begin
            cnt_r <= 4'h0;
            state_r <= PMS_S_DATA;
          end
        end
        PMS_S_DATA: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == PMS_CNT_DATA_LAST) begin
            cnt_r <= 4'h0;
            state_r <= PMS_S_IDLE;
          end
        end
        default: begin
          state_r <= PMS_S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Data shifter: read word out, write word in
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      shift_r <= 16'h0;
    end else if (rise) begin
      // Loaded in the first turnaround bit, once the last register address bit is in.
      if (state_r == PMS_S_TA && cnt_r != PMS_CNT_TA_LAST) begin
        shift_r <= rd_word;
      end else if (state_r == PMS_S_TA && is_read_r) begin
        shift_r <= {shift_r[14:0], 1'b0};
      end else if (state_r == PMS_S_DATA) begin
        shift_r <= {shift_r[14:0], bit_in};
      end
    end
  end

  // ----------------------------------------------------------------
  // Line driver
  // ----------------------------------------------------------------
  // Outputs change right after a seen rising edge, so the station samples a settled bit one edge later.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mdio_o_r <= 1'b1;
      mdio_oe_r <= 1'b0;
    end else if (rise) begin
      mdio_o_r <= 1'b1;
      mdio_oe_r <= 1'b0;
      if (state_r == PMS_S_TA && hit_r && is_read_r) begin
        mdio_oe_r <= 1'b1;
        mdio_o_r <= (cnt_r == PMS_CNT_TA_LAST) ? shift_r[15] : 1'b0;
      end else if (state_r == PMS_S_DATA && hit_r && is_read_r && cnt_r != PMS_CNT_DATA_LAST) begin
        mdio_oe_r <= 1'b1;
        mdio_o_r <= shift_r[15];
      end
    end
  end

  assign link.phy_mdio_o = mdio_o_r;
  assign link.phy_mdio_oe = mdio_oe_r;

  // ----------------------------------------------------------------
  // Register file and write notice
  // ----------------------------------------------------------------
  logic wr_fire;

  assign wr_fire = rise && state_r == PMS_S_DATA && cnt_r == PMS_CNT_DATA_LAST && hit_r && !is_read_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < PMS_NUM_REGS; i++) begin
        regs_r[i] <= 16'h0;
      end
      regs_r[PMS_REG_BASIC_STATUS] <= PMS_BSR_RESET;
    end else if (wr_fire && reg_r != PMS_REG_BASIC_STATUS) begin
      // Basic status is read-only, so a write leaves it alone.
      regs_r[reg_r] <= {shift_r[14:0], bit_in};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_stb_r <= 1'b0;
      wr_addr_r <= 5'h0;
      wr_data_r <= 16'h0;
    end else begin
      wr_stb_r <= wr_fire;
      if (wr_fire) begin
        wr_addr_r <= reg_r;
        wr_data_r <= {shift_r[14:0], bit_in};
      end
    end
  end

endmodule // pms_phy_slave
`default_nettype wire

// >>> logic/pms_station.sv
// Station end of the management link: makes the clock and runs one read or write frame per request.
// Assumes the user waits for done before the next request.
`timescale 1ns/100ps
`default_nettype none
module pms_station
  import pms_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Management link
  pms_if.station link,
  // Request
  input wire logic req,
  input wire logic req_write,
  input wire logic req_preamble,
  input wire logic [4:0] req_phy_addr,
  input wire logic [4:0] req_reg_addr,
  input wire logic [15:0] req_wdata,
  // Answer
  output logic busy_r,
  output logic done_r,
  output logic [15:0] rdata_r
);

  // ----------------------------------------------------------------
  // Data line input synchroniser
  // ----------------------------------------------------------------
  logic mdio_s1_r;
  logic mdio_s2_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mdio_s1_r <= 1'b1;
      mdio_s2_r <= 1'b1;
    end else begin
      mdio_s1_r <= link.mdio;
      mdio_s2_r <= mdio_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  pms_master_e state_r;
  logic [2:0] div_r;
  logic [6:0] slot_r;
  logic [63:0] frame_r;
  logic rd_r;
  logic launch_r;
  logic mdc_r;
  logic mdio_o_r;
  logic mdio_oe_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= PMS_M_IDLE;
      div_r <= 3'h0;
      slot_r <= 7'h0;
      frame_r <= 64'h0;
      rd_r <= 1'b0;
      launch_r <= 1'b0;
      mdc_r <= 1'b0;
      mdio_o_r <= 1'b1;
      mdio_oe_r <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      rdata_r <= 16'h0;
    end else begin
      done_r <= 1'b0;
      launch_r <= 1'b0;
      case (state_r)
        PMS_M_IDLE: begin
          if (req) begin
            frame_r <= {PMS_PREAMBLE, PMS_START, req_write ? PMS_OP_WRITE : PMS_OP_READ,
                        req_phy_addr, req_reg_addr, PMS_TA_WRITE, req_wdata};
            slot_r <= req_preamble ? 7'h0 : PMS_SLOT_NOPRE;
            rd_r <= ~req_write;
            div_r <= 3'h0;
            busy_r <= 1'b1;
            state_r <= PMS_M_RUN;
          end
        end
        PMS_M_RUN: begin
          div_r <= (div_r == PMS_MDC_LAST) ? 3'h0 : div_r + 3'h1;
          if (div_r == 3'h0) begin
            // Rising edge: the slave samples the bit that stands now.
            mdc_r <= 1'b1;
            launch_r <= 1'b1;
            if (rd_r && slot_r > PMS_SLOT_DATA && slot_r <= PMS_SLOT_END) begin
              rdata_r <= {rdata_r[14:0], mdio_s2_r};
            end
          end else if (div_r == PMS_MDC_HALF) begin
            mdc_r <= 1'b0;
            if (slot_r == PMS_SLOT_END) begin
              busy_r <= 1'b0;
              done_r <= 1'b1;
              state_r <= PMS_M_IDLE;
            end else begin
              slot_r <= slot_r + 7'h1;
            end
          end
          // The next bit moves one clock after the rise, so the slave's synchronised sample still holds the old one.
          if (launch_r) begin
            if (slot_r == PMS_SLOT_END) begin
              mdio_oe_r <= 1'b0;
              mdio_o_r <= 1'b1;
            end else begin
              mdio_o_r <= frame_r[6'(PMS_FRAME_BITS - 1 - int'(slot_r))];
              mdio_oe_r <= ~(rd_r && slot_r >= PMS_SLOT_TA);
            end
          end
        end
        default: begin
          state_r <= PMS_M_IDLE;
        end
      endcase
    end
  end

  assign link.mdc = mdc_r;
  assign link.sta_mdio_o = mdio_o_r;
  assign link.sta_mdio_oe = mdio_oe_r;

endmodule // pms_station
`default_nettype wire

// >>> testbench/pms_link_props.sv
// Checker of the management link: watches both enables, the resolved line and the clock.
// Assumes both ends share one system clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module pms_link_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Link signals
  input wire logic mdc,
  input wire logic sta_mdio_o,
  input wire logic sta_mdio_oe,
  input wire logic phy_mdio_o,
  input wire logic phy_mdio_oe,
  input wire logic mdio
);
  // --------
  // Helper logic
  // --------
  // Counts how long the slave has been driving, so a short or long answer is seen at its end.
  logic [7:0] drive_len_r;
  always_ff @(posedge sys_clk) begin
    if (rst || !phy_mdio_oe) begin
      drive_len_r <= 8'h00;
    end else begin
      drive_len_r <= drive_len_r + 8'h01;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence ta1_float_s;
    !phy_mdio_oe [*8];
  endsequence
  sequence ta2_zero_s;
    phy_mdio_oe && !phy_mdio_o;
  endsequence

  AST_ONE_DRIVER: assert property (!(sta_mdio_oe && phy_mdio_oe))
    else $error("both ends drive the line");
  AST_TA1_FLOAT: assert property ($fell(sta_mdio_oe) |-> ta1_float_s)
    else $error("slave drove in the first turnaround bit");
  AST_TA2_ZERO: assert property ($rose(phy_mdio_oe) |-> ta2_zero_s [*8])
    else $error("second turnaround bit not a full zero");
  AST_DRIVE_LEN: assert property ($fell(phy_mdio_oe) |-> drive_len_r inside {[8'h87:8'h89]})
    else $error("slave answer not seventeen bit times");
  AST_PULLUP: assert property (!sta_mdio_oe && !phy_mdio_oe |-> mdio)
    else $error("released line not high");
  AST_MDC_HIGH: assert property ($rose(mdc) |-> mdc [*4])
    else $error("clock high phase too short");
  AST_MDC_LOW: assert property ($fell(mdc) |-> !mdc [*4])
    else $error("clock low phase too short");
  AST_STA_EDGE: assert property (sta_mdio_oe && $changed(sta_mdio_o) |-> mdc && $past(mdc) && !$past(mdc, 2))
    else $error("station data did not move one clock after a rising clock");
endmodule // pms_link_props
`default_nettype wire

// >>> testbench/phy_mgmt_serial_slave_test.sv
// Self-checking bench: station and slave on one link, a second slave fed by hand-made frames.
// Assumes the design files and the link checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin n_fail++; \
  $display("[FAIL] %s expected %h seen %h", what, exp, got); end end
module phy_mgmt_serial_slave_test;
  import pms_pkg::*;
  typedef struct packed {
    logic wr;
    logic pre;
    logic [4:0] phy;
    logic [4:0] rg;
    logic [15:0] wd;
    logic [15:0] rd;
    logic stb;
  } pms_row_s;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  logic req_write = 1'b0;
  logic req_preamble = 1'b0;
  logic [4:0] req_phy_addr = 5'h00;
  logic [4:0] req_reg_addr = 5'h00;
  logic [15:0] req_wdata = 16'h0000;
  logic busy_r, done_r, wr_stb_r, wr_stb_b;
  logic [15:0] rdata_r, wr_data_r, wr_data_b;
  logic [4:0] wr_addr_r;
  int n_fail = 0;
  int n_tests = 0;
  int n_stb = 0;
  int n_stb_b = 0;
  int n_oe_b = 0;
  // The foreign-address read row expects the pull-up level in every data bit.
  pms_row_s rows [11] = '{
    '{1'b1, 1'b1, 5'h10, 5'h05, 16'ha5c3, 16'h0000, 1'b1},
    '{1'b0, 1'b0, 5'h10, 5'h05, 16'h0000, 16'ha5c3, 1'b0},
    '{1'b1, 1'b0, 5'h10, 5'h1f, 16'h8001, 16'h0000, 1'b1},
    '{1'b0, 1'b1, 5'h10, 5'h1f, 16'h0000, 16'h8001, 1'b0},
    '{1'b0, 1'b0, 5'h10, 5'h01, 16'h0000, 16'h0040, 1'b0},
    '{1'b1, 1'b0, 5'h10, 5'h01, 16'hffff, 16'h0000, 1'b1},
    '{1'b0, 1'b0, 5'h10, 5'h01, 16'h0000, 16'h0040, 1'b0},
    '{1'b1, 1'b0, 5'h03, 5'h05, 16'h0000, 16'h0000, 1'b0},
    '{1'b0, 1'b0, 5'h03, 5'h05, 16'h0000, 16'hffff, 1'b0},
    '{1'b0, 1'b0, 5'h10, 5'h05, 16'h0000, 16'ha5c3, 1'b0},
    '{1'b0, 1'b0, 5'h10, 5'h00, 16'h0000, 16'h0000, 1'b0}
  };

  pms_if link_a();
  pms_if link_b();
  pms_station pms_station_inst (.sys_clk(sys_clk), .rst(rst), .link(link_a), .req(req), .req_write(req_write),
    .req_preamble(req_preamble), .req_phy_addr(req_phy_addr), .req_reg_addr(req_reg_addr), .req_wdata(req_wdata),
    .busy_r(busy_r), .done_r(done_r), .rdata_r(rdata_r));
  pms_phy_slave pms_phy_slave_inst (.sys_clk(sys_clk), .rst(rst), .link(link_a), .wr_stb_r(wr_stb_r),
    .wr_addr_r(wr_addr_r), .wr_data_r(wr_data_r));
  pms_phy_slave pms_phy_slave_inst_b (.sys_clk(sys_clk), .rst(rst), .link(link_b), .wr_stb_r(wr_stb_b),
    .wr_addr_r(), .wr_data_r(wr_data_b));
  pms_link_props pms_link_props_inst (.sys_clk(sys_clk), .rst(rst), .mdc(link_a.mdc),
    .sta_mdio_o(link_a.sta_mdio_o), .sta_mdio_oe(link_a.sta_mdio_oe), .phy_mdio_o(link_a.phy_mdio_o),
    .phy_mdio_oe(link_a.phy_mdio_oe), .mdio(link_a.mdio));

  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (wr_stb_r === 1'b1) n_stb++;
    if (wr_stb_b === 1'b1) n_stb_b++;
    if (link_b.phy_mdio_oe === 1'b1) n_oe_b++;
  end

  task automatic close_out();
    if (n_fail == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // A poked run raises a second request mid-frame, which must be ignored.
  task automatic run(input pms_row_s r, input bit poke);
    int k;
    k = 0;
    n_stb = 0;
    @(posedge sys_clk);
    req <= 1'b1;
    req_write <= r.wr;
    req_preamble <= r.pre;
    req_phy_addr <= r.phy;
    req_reg_addr <= r.rg;
    req_wdata <= r.wd;
    do begin
      @(posedge sys_clk);
      req <= poke && k == 100;
      k++;
      #1;
    end while (done_r !== 1'b1 && k < 700);
    `CHK("done", 1'b1, done_r)
    if (!r.wr) `CHK("rdata", r.rd, rdata_r)
    repeat (10) @(posedge sys_clk);
    #1;
    `CHK("busy", 1'b0, busy_r)
    `CHK("stb", int'(r.stb), n_stb)
    if (r.stb) `CHK("waddr", r.rg, wr_addr_r)
    if (r.stb) `CHK("wdata", r.wd, wr_data_r)
  endtask

  // The hand-made clock only runs within frames; data moves on its fall, well clear of the rise.
  task automatic bits_b(input logic [63:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      link_b.sta_mdio_o <= v[i];
      repeat (4) @(posedge sys_clk);
      link_b.mdc <= 1'b1;
      repeat (4) @(posedge sys_clk);
      link_b.mdc <= 1'b0;
    end
  endtask

  initial begin
    #2000000;
    n_fail++;
    close_out();
  end

  initial begin
    link_b.mdc = 1'b0;
    link_b.sta_mdio_o = 1'b1;
    link_b.sta_mdio_oe = 1'b0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    `CHK("rst rdata", 16'h0000, rdata_r)
    `CHK("rst line", 1'b1, link_a.mdio)
    foreach (rows[i]) run(rows[i], 1'b0);
    run('{1'b1, 1'b0, 5'h10, 5'h07, 16'h1234, 16'h0000, 1'b1}, 1'b1);
    run('{1'b0, 1'b1, 5'h10, 5'h07, 16'h0000, 16'h1234, 1'b0}, 1'b0);
    // --------
    // Reset in mid-frame
    // --------
    @(posedge sys_clk);
    req <= 1'b1;
    req_write <= 1'b1;
    req_phy_addr <= 5'h10;
    req_reg_addr <= 5'h07;
    req_wdata <= 16'hbeef;
    @(posedge sys_clk);
    req <= 1'b0;
    repeat (150) @(posedge sys_clk);
    rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    `CHK("rst busy", 1'b0, busy_r)
    `CHK("rst mdc", 1'b0, link_a.mdc)
    `CHK("rst line", 1'b1, link_a.mdio)
    run('{1'b0, 1'b0, 5'h10, 5'h07, 16'h0000, 16'h0000, 1'b0}, 1'b0);
    run('{1'b0, 1'b0, 5'h10, 5'h01, 16'h0000, 16'h0040, 1'b0}, 1'b0);
    // --------
    // Hand-made frames to the second slave
    // --------
    @(posedge sys_clk);
    link_b.sta_mdio_oe <= 1'b1;
    bits_b(64'hffffffff, 32);
    bits_b({4'b0111, 5'h10, 5'h05, 18'h3ffff}, 32);
    link_b.sta_mdio_oe <= 1'b0;
    bits_b(64'h1, 1);
    #2010;
    `CHK("bad op drive", 0, n_oe_b)
    `CHK("bad op write", 0, n_stb_b)
    @(posedge sys_clk);
    link_b.sta_mdio_oe <= 1'b1;
    bits_b({4'b0101, 5'h10, 5'h0a, 2'b10, 16'hc3a5}, 32);
    link_b.sta_mdio_oe <= 1'b0;
    bits_b(64'h1, 1);
    #2010;
    `CHK("hand write", 1, n_stb_b)
    `CHK("hand data", 16'hc3a5, wr_data_b)
    close_out();
  end
endmodule // phy_mgmt_serial_slave_test
`default_nettype wire
